// file: hdl/uhi_top.sv
// host data port, serial link and interrupt status for one uart channel
//
// What this block does
// - every register except six-bit route is eight bits wide
// - hold read pops oldest received character
// - received bit zero is first serial bit
// - hold write pushes byte into transmit fifo
// - transmitter sends bit zero right after start
// - interrupt pin asserts on enabled set status
// - each pin enable gates same-position status bit
// - pin enables affect only pin, never status
// - status read clears latched status bits
// - bit 7 sets on any handshake edge
// - bit 6 rx empty, invertible by mode
// - bit 5 sets when transmit fifo empty
// - bit 4 sets at transmit trigger level
// - bit 4 self-clears below transmit trigger
// - bit 3 rx trigger level, invertible by mode
// - bit 2 sets on enabled aux status
// - bit 1 on special, break, address char
// - bit 0 on routed line errors
// - route bits 5..3 noise break framing
// - route bits 2..0 parity overrun timeout
// - status register resets to 0x60
`timescale 1ns/1ns
module uhi_top #(
    parameter int FIFO_DEPTH = uhi_pkg::FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [7:0] host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    output logic host_rvalid_o,
    output logic host_tx_room_o,
    input wire logic link_clk_i,
    input wire logic rx_i,
    output logic tx_o,
    input wire logic cts_n_i,
    input wire logic [5:0] line_status_i,
    input wire logic [7:0] aux_status_i,
    input wire logic special_char_i,
    input wire logic break_i,
    input wire logic multidrop_addr_i,
    output logic irq_n_o
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int DW = uhi_pkg::DATA_W;

    // pin synchronisers
    logic cts_m_r, cts_s_r, cts_d_r;
    logic rx_m_r, rx_s_r;
    logic lclk_m_r, lclk_s_r, lclk_d_r;
    logic lclk_rise, lclk_fall;
    // software registers
    logic [DW-1:0] pin_en_r;
    logic [5:0] route_r;
    logic [DW-1:0] aux_en_r;
    logic [DW-1:0] mode_ctl_r;
    logic [DW-1:0] trig_r;
    logic [DW-1:0] stat_r;
    logic [DW-1:0] stat_nxt;
    logic [DW-1:0] stat_set;
    logic [DW-1:0] stat_clr;
    // host port
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rd_mux;
    logic rvalid_r;
    logic room_r;
    logic irq_n_r;
    logic irq_any;
    logic rd_hold, rd_stat, wr_hold;
    // fifo side
    logic rx_in_ready, rx_out_valid;
    logic [DW-1:0] rx_out_data;
    logic [CW-1:0] rx_count, tx_count, rx_trig, tx_trig;
    logic tx_in_ready, tx_out_valid, tx_pop;
    logic [DW-1:0] tx_out_data;
    // serial link
    uhi_pkg::uhi_link_state_t rx_state_r, tx_state_r;
    logic [2:0] rx_cnt_r, tx_cnt_r;
    logic [DW-1:0] rx_sh_r, tx_sh_r;
    logic rx_push_r, frame_err_r, overrun;
    logic tx_r;
    logic [5:0] line_err;

    ////////////////////////////////////////////////////////////////////////////
    // two flops on every pin, third flop only for edge finding
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cts_m_r <= 1'b1;
            cts_s_r <= 1'b1;
            cts_d_r <= 1'b1;
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            lclk_m_r <= 1'b1; // link clock idles high
            lclk_s_r <= 1'b1; // no false edge after reset
            lclk_d_r <= 1'b1;
        end else if (ce_i) begin
            cts_m_r <= cts_n_i;
            cts_s_r <= cts_m_r;
            cts_d_r <= cts_s_r;
            rx_m_r <= rx_i;
            rx_s_r <= rx_m_r;
            lclk_m_r <= link_clk_i;
            lclk_s_r <= lclk_m_r;
            lclk_d_r <= lclk_s_r;
        end
    end

    assign lclk_rise = lclk_s_r & ~lclk_d_r;
    assign lclk_fall = ~lclk_s_r & lclk_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // host access decode
    assign rd_hold = host_rd_i & (host_addr_i == uhi_pkg::OFF_HOLD);
    assign rd_stat = ce_i & host_rd_i & (host_addr_i == uhi_pkg::OFF_STATUS);
    assign wr_hold = host_wr_i & (host_addr_i == uhi_pkg::OFF_HOLD);

    // receive fifo, drained by host reads of the hold register
    uhi_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .CW(CW)) u_rx_fifo (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .in_valid_i(rx_push_r),
        .in_ready_o(rx_in_ready),
        .in_data_i(rx_sh_r),
        .out_valid_o(rx_out_valid),
        .out_ready_i(rd_hold),
        .out_data_o(rx_out_data),
        .count_o(rx_count)
    );

    // transmit fifo, filled by host writes of the hold register
    uhi_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .CW(CW)) u_tx_fifo (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .in_valid_i(wr_hold),
        .in_ready_o(tx_in_ready),
        .in_data_i(host_wdata_i),
        .out_valid_o(tx_out_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_out_data),
        .count_o(tx_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // writable control registers, eight bits each except six-bit route
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            pin_en_r <= uhi_pkg::RST_ZERO;
            route_r <= uhi_pkg::RST_ROUTE;
            aux_en_r <= uhi_pkg::RST_ZERO;
            mode_ctl_r <= uhi_pkg::RST_ZERO;
            trig_r <= uhi_pkg::RST_TRIG;
        end else if (ce_i && host_wr_i) begin
            unique case (host_addr_i)
                uhi_pkg::OFF_PIN_EN: pin_en_r <= host_wdata_i;
                uhi_pkg::OFF_ROUTE: route_r <= host_wdata_i[5:0];
                uhi_pkg::OFF_AUX_EN: aux_en_r <= host_wdata_i;
                uhi_pkg::OFF_MODE_CTL: mode_ctl_r <= host_wdata_i;
                uhi_pkg::OFF_TRIG: trig_r <= host_wdata_i;
                default: ;
            endcase
        end
    end

    // read data mux, unused bits and unmapped offsets read zero
    always_comb begin
        rd_mux = uhi_pkg::RST_ZERO;
        unique case (host_addr_i)
            uhi_pkg::OFF_HOLD: rd_mux = rx_out_valid ? rx_out_data : uhi_pkg::RST_ZERO;
            uhi_pkg::OFF_PIN_EN: rd_mux = pin_en_r;
            uhi_pkg::OFF_STATUS: rd_mux = stat_r;
            uhi_pkg::OFF_ROUTE: rd_mux = {2'h0, route_r};
            uhi_pkg::OFF_AUX_EN: rd_mux = aux_en_r;
            uhi_pkg::OFF_MODE_CTL: rd_mux = mode_ctl_r;
            uhi_pkg::OFF_TRIG: rd_mux = trig_r;
            uhi_pkg::OFF_TX_LEVEL: rd_mux = DW'(tx_count);
            uhi_pkg::OFF_RX_LEVEL: rd_mux = DW'(rx_count);
            default: rd_mux = uhi_pkg::RST_ZERO;
        endcase
    end

    // registered read answer one cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_r <= uhi_pkg::RST_ZERO;
            rvalid_r <= 1'b0;
            room_r <= 1'b1;
        end else if (ce_i) begin
            rvalid_r <= host_rd_i;
            room_r <= tx_in_ready;
            if (host_rd_i) begin
                rdata_r <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver, samples on link clock rising edge, lsb first
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rx_state_r <= uhi_pkg::UHI_IDLE;
            rx_cnt_r <= '0;
            rx_sh_r <= uhi_pkg::RST_ZERO;
            rx_push_r <= 1'b0;
            frame_err_r <= 1'b0;
        end else if (ce_i) begin
            rx_push_r <= 1'b0;
            frame_err_r <= 1'b0;
            if (lclk_rise) begin
                unique case (rx_state_r)
                    uhi_pkg::UHI_IDLE: begin
                        if (!rx_s_r) begin
                            rx_state_r <= uhi_pkg::UHI_DATA;
                            rx_cnt_r <= '0;
                        end
                    end
                    uhi_pkg::UHI_DATA: begin
                        rx_sh_r <= {rx_s_r, rx_sh_r[DW-1:1]};
                        rx_cnt_r <= rx_cnt_r + 1'b1;
                        if (rx_cnt_r == uhi_pkg::LAST_BIT) begin
                            rx_state_r <= uhi_pkg::UHI_STOP;
                        end
                    end
                    uhi_pkg::UHI_STOP: begin
                        rx_push_r <= rx_s_r;
                        frame_err_r <= ~rx_s_r;
                        rx_state_r <= uhi_pkg::UHI_IDLE;
                    end
                    default: rx_state_r <= uhi_pkg::UHI_IDLE;
                endcase
            end
        end
    end

    // character lost because receive fifo is full
    assign overrun = rx_push_r & ~rx_in_ready;

    // transmitter, shifts on link clock falling edge
    assign tx_pop = lclk_fall & tx_out_valid & (tx_state_r == uhi_pkg::UHI_IDLE);

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            tx_state_r <= uhi_pkg::UHI_IDLE;
            tx_cnt_r <= '0;
            tx_sh_r <= uhi_pkg::RST_ZERO;
            tx_r <= 1'b1;
        end else if (ce_i && lclk_fall) begin
            unique case (tx_state_r)
                uhi_pkg::UHI_IDLE: begin
                    if (tx_out_valid) begin
                        tx_r <= 1'b0;
                        tx_sh_r <= tx_out_data;
                        tx_cnt_r <= '0;
                        tx_state_r <= uhi_pkg::UHI_DATA;
                    end
                end
                uhi_pkg::UHI_DATA: begin
                    tx_r <= tx_sh_r[0];
                    tx_sh_r <= {1'b0, tx_sh_r[DW-1:1]};
                    tx_cnt_r <= tx_cnt_r + 1'b1;
                    if (tx_cnt_r == uhi_pkg::LAST_BIT) begin
                        tx_state_r <= uhi_pkg::UHI_STOP;
                    end
                end
                uhi_pkg::UHI_STOP: begin
                    tx_r <= 1'b1;
                    tx_state_r <= uhi_pkg::UHI_IDLE;
                end
                default: tx_state_r <= uhi_pkg::UHI_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status set conditions, independent of pin enables
    assign tx_trig = CW'(trig_r[3:0]) << uhi_pkg::TRIG_SHIFT;
    assign rx_trig = CW'(trig_r[7:4]) << uhi_pkg::TRIG_SHIFT;
    // own framing and overrun events merge into line errors
    assign line_err = line_status_i
        | {2'h0, frame_err_r, 1'b0, overrun, 1'b0};

    assign stat_set[uhi_pkg::ST_HANDSHAKE] = cts_s_r ^ cts_d_r;
    assign stat_set[uhi_pkg::ST_RX_EMPTY] = (rx_count == '0)
        ^ mode_ctl_r[uhi_pkg::MODE_RX_EMPTY_INV];
    assign stat_set[uhi_pkg::ST_TX_EMPTY] = (tx_count == '0);
    assign stat_set[uhi_pkg::ST_TX_LEVEL] = (tx_count >= tx_trig);
    assign stat_set[uhi_pkg::ST_RX_LEVEL] = (rx_count >= rx_trig)
        ^ mode_ctl_r[uhi_pkg::MODE_RX_LEVEL_INV];
    assign stat_set[uhi_pkg::ST_AUX] = |(aux_status_i & aux_en_r);
    assign stat_set[uhi_pkg::ST_SPECIAL] = special_char_i | break_i | multidrop_addr_i;
    assign stat_set[uhi_pkg::ST_LINE_ERR] = |(line_err & route_r);

    // clear on status read, bit 4 also drops below trigger
    always_comb begin
        stat_clr = {DW{rd_stat}};
        stat_clr[uhi_pkg::ST_TX_LEVEL] = rd_stat | (tx_count < tx_trig);
    end

    // per-bit update, a set wins over a clear in the same cycle
    for (genvar i = 0; i < DW; i++) begin : g_status
        assign stat_nxt[i] = stat_set[i] | (stat_r[i] & ~stat_clr[i]);
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            stat_r <= uhi_pkg::RST_STATUS;
        end else if (ce_i) begin
            stat_r <= stat_nxt;
        end
    end

    // active-low interrupt pin, bit-for-bit gating
    assign irq_any = |(stat_r & pin_en_r);

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            irq_n_r <= 1'b1;
        end else if (ce_i) begin
            irq_n_r <= ~irq_any;
        end
    end

    // outputs straight from flops
    assign host_rdata_o = rdata_r;
    assign host_rvalid_o = rvalid_r;
    assign host_tx_room_o = room_r;
    assign tx_o = tx_r;
    assign irq_n_o = irq_n_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_irq_gate;
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i |=> (irq_n_o == !$past(irq_any));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq pin not gated status");

    property p_irq_release;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && !irq_any) ##1 (ce_i && !irq_any) |=> irq_n_o;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq pin held low");

    property p_status_clear;
        @(posedge mclk_i) disable iff (!rstn_i)
        (rd_stat && !stat_set[uhi_pkg::ST_SPECIAL]) |=> !stat_r[uhi_pkg::ST_SPECIAL];
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared");

    property p_cts_edge;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && (cts_s_r != cts_d_r)) |=> stat_r[uhi_pkg::ST_HANDSHAKE];
    endproperty
    a_cts_edge: assert property (p_cts_edge) else $error("handshake edge missed");

    property p_rx_empty;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && (rx_count == '0) && !mode_ctl_r[uhi_pkg::MODE_RX_EMPTY_INV])
            |=> stat_r[uhi_pkg::ST_RX_EMPTY];
    endproperty
    a_rx_empty: assert property (p_rx_empty) else $error("rx empty flag missed");

    property p_tx_empty;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && (tx_count == '0)) |=> stat_r[uhi_pkg::ST_TX_EMPTY];
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag missed");

    property p_tx_level_drop;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && (tx_count < tx_trig)) |=> !stat_r[uhi_pkg::ST_TX_LEVEL];
    endproperty
    a_tx_level_drop: assert property (p_tx_level_drop) else $error("tx level stuck");

    property p_line_route;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && |(line_status_i & route_r)) |=> stat_r[uhi_pkg::ST_LINE_ERR];
    endproperty
    a_line_route: assert property (p_line_route) else $error("line error not routed");

    property p_pop_data;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && rd_hold && rx_out_valid) |=> (host_rvalid_o && host_rdata_o == $past(rx_out_data));
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("hold read data wrong");

    property p_tx_start;
        @(posedge mclk_i) disable iff (!rstn_i)
        (ce_i && tx_pop) |=> (!tx_o && tx_state_r == uhi_pkg::UHI_DATA);
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit missing");

    c_irq: cover property (@(posedge mclk_i) disable iff (!rstn_i) $fell(irq_n_o));
    c_rx_char: cover property (@(posedge mclk_i) disable iff (!rstn_i) rx_push_r && rx_in_ready);
    c_tx_stop: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        tx_state_r == uhi_pkg::UHI_STOP && lclk_fall && ce_i);

endmodule // uhi_top

// file: include/uhi_pkg.sv
// shared constants and types for the uart host data and interrupt block
package uhi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths and depths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int FRAME_BITS = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // trigger nibble is scaled by this shift to a fifo count
    localparam int TRIG_SHIFT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFF_HOLD = 8'h00;
    localparam logic [7:0] OFF_PIN_EN = 8'h01;
    localparam logic [7:0] OFF_STATUS = 8'h02;
    localparam logic [7:0] OFF_ROUTE = 8'h03;
    localparam logic [7:0] OFF_AUX_EN = 8'h07;
    localparam logic [7:0] OFF_MODE_CTL = 8'h0A;
    localparam logic [7:0] OFF_TRIG = 8'h10;
    localparam logic [7:0] OFF_TX_LEVEL = 8'h11;
    localparam logic [7:0] OFF_RX_LEVEL = 8'h12;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h60;
    localparam logic [7:0] RST_TRIG = 8'hFF;
    localparam logic [5:0] RST_ROUTE = 6'h00;

    ////////////////////////////////////////////////////////////////////////////
    // status bit positions
    localparam int ST_HANDSHAKE = 7;
    localparam int ST_RX_EMPTY = 6;
    localparam int ST_TX_EMPTY = 5;
    localparam int ST_TX_LEVEL = 4;
    localparam int ST_RX_LEVEL = 3;
    localparam int ST_AUX = 2;
    localparam int ST_SPECIAL = 1;
    localparam int ST_LINE_ERR = 0;

    // mode_control_two bit positions
    localparam int MODE_RX_EMPTY_INV = 3;
    localparam int MODE_RX_LEVEL_INV = 2;

    // line error vector positions
    localparam int LE_FRAMING = 3;
    localparam int LE_OVERRUN = 1;

    ////////////////////////////////////////////////////////////////////////////
    // serial link state
    typedef enum logic [2:0] {
        UHI_IDLE = 3'h1,
        UHI_DATA = 3'h2,
        UHI_STOP = 3'h4
    } uhi_link_state_t;

endpackage

// file: hdl/uhi_fifo.sv
// synchronous show-ahead fifo with valid and ready on both sides
`timescale 1ns/1ns
module uhi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [CW-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    // handshakes, frozen while clock enable is low
    assign in_ready_o = (count_r != FULL);
    assign out_valid_o = (count_r != '0);
    assign push = ce_i & in_valid_i & in_ready_o;
    assign pop = ce_i & out_ready_i & out_valid_o;
    assign out_data_o = mem[rd_ptr_r];
    assign count_o = count_r;

    ////////////////////////////////////////////////////////////////////////////
    // storage array
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // uhi_fifo

// file: bench/uhi_link_model.sv
// serial far end: link clock, receive line drive and transmit capture
`timescale 1ns/1ns
module uhi_link_model (
    output logic link_clk_o,
    output logic rx_o,
    input wire logic tx_i
);
    // clock stands high and line idles high between frames
    initial begin
        link_clk_o = 1'b1;
        rx_o = 1'b1;
    end

    // one frame each way: d goes out on rx, q is captured from tx
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            link_clk_o = 1'b0;
            rx_o = f[i];
            #63;
            link_clk_o = 1'b1;
            #62;
            if (i > 0 && i < 9) q[i-1] = tx_i;
        end
    endtask
endmodule // uhi_link_model

// file: bench/tb_top.sv
// self-checking bench for the uart host data and interrupt block
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'b0;
    logic ce = 1'b1;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic hwr = 1'b0;
    logic hrd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rvalid;
    logic room;
    logic link_clk;
    logic rx;
    logic tx;
    logic cts_n = 1'b1;
    logic [5:0] ls = 6'h00;
    logic [7:0] aux = 8'h00;
    logic [2:0] sp = 3'h0;
    logic irq_n;
    int mismatches = 0;
    int n_compared = 0;

    ////////////////////////////////////////////////////////////////////////////
    // clock, design and far end
    always #5 mclk = ~mclk;

    uhi_top #(.FIFO_DEPTH(32)) dut (.mclk_i(mclk), .rstn_i(rstn), .ce_i(ce),
        .host_addr_i(addr), .host_wr_i(hwr), .host_rd_i(hrd), .host_wdata_i(wdata),
        .host_rdata_o(rdata), .host_rvalid_o(rvalid), .host_tx_room_o(room),
        .link_clk_i(link_clk), .rx_i(rx), .tx_o(tx), .cts_n_i(cts_n),
        .line_status_i(ls), .aux_status_i(aux), .special_char_i(sp[0]),
        .break_i(sp[1]), .multidrop_addr_i(sp[2]), .irq_n_o(irq_n));

    uhi_link_model lm (.link_clk_o(link_clk), .rx_o(rx), .tx_i(tx));

    ////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        hwr = 1'b1;
        @(negedge mclk);
        hwr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        addr = a;
        hrd = 1'b1;
        @(negedge mclk);
        hrd = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        d = rdata;
    endtask

    // status read, masked compare
    task automatic st(input logic [7:0] m, input logic [7:0] e);
        logic [7:0] s;
        rd(8'h02, s);
        chk(s & m, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [7:0] v;
        rd(8'h01, v);
        chk(v, 8'h00);
        rd(8'h03, v);
        chk(v, 8'h00);
        st(8'hFF, 8'h60);
        chk({7'h00, irq_n}, 8'h01);
        $display("reset test done");
    endtask

    task automatic t_irq();
        cts_n = 1'b0;
        idle(6);
        chk({7'h00, irq_n}, 8'h01);
        wr(8'h01, 8'h80);
        idle(2);
        chk({7'h00, irq_n}, 8'h00);
        st(8'h80, 8'h80);
        idle(2);
        chk({7'h00, irq_n}, 8'h01);
        cts_n = 1'b1;
        idle(6);
        wr(8'h01, 8'h1F);
        idle(2);
        chk({7'h00, irq_n}, 8'h01);
        st(8'h80, 8'h80);
        wr(8'h01, 8'h00);
        $display("interrupt test done");
    endtask

    task automatic t_route();
        logic [7:0] v;
        wr(8'h03, 8'hFF);
        rd(8'h03, v);
        chk(v, 8'h3F);
        for (int i = 0; i < 6; i++) begin
            wr(8'h03, 8'h01 << i);
            ls = ~(6'h01 << i);
            idle(2);
            ls = 6'h00;
            st(8'h01, 8'h00);
            ls = 6'h01 << i;
            idle(2);
            ls = 6'h00;
            st(8'h01, 8'h01);
        end
        $display("route test done");
    endtask

    task automatic t_events();
        wr(8'h07, 8'h80);
        aux = 8'h7F;
        idle(2);
        aux = 8'h00;
        st(8'h04, 8'h00);
        aux = 8'h80;
        idle(2);
        aux = 8'h00;
        st(8'h04, 8'h04);
        for (int i = 0; i < 3; i++) begin
            sp = 3'h1 << i;
            idle(1);
            sp = 3'h0;
            st(8'h02, 8'h02);
        end
        // clock enable low freezes status
        ce = 1'b0;
        sp = 3'h1;
        idle(2);
        sp = 3'h0;
        ce = 1'b1;
        st(8'h02, 8'h00);
        $display("event test done");
    endtask

    // fill transmit fifo until refused, then stream both ways
    task automatic t_stream();
        logic [7:0] v;
        logic [7:0] q;
        wr(8'h10, 8'h11);
        for (int i = 0; i < 33; i++) wr(8'h00, 8'(i));
        idle(2);
        chk({7'h00, room}, 8'h00);
        rd(8'h02, v);
        st(8'h30, 8'h10);
        for (int i = 0; i < 32; i++) begin
            lm.xfer(~8'(i), q);
            chk(q, 8'(i));
            if (i == 30) st(8'h10, 8'h00);
        end
        idle(6);
        chk({7'h00, room}, 8'h01);
        st(8'h68, 8'h28);
        for (int i = 0; i < 32; i++) begin
            rd(8'h00, v);
            chk(v, ~8'(i));
        end
        rd(8'h00, v);
        chk(v, 8'h00);
        wr(8'h0A, 8'h0C);
        rd(8'h02, v);
        st(8'h48, 8'h08);
        wr(8'h0A, 8'h00);
        $display("stream test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // verdict
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_irq();
        t_route();
        t_events();
        t_stream();
        tally_and_finish();
    end

    // watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule // tb_top
